/* File: cmsc_top.sv */
`timescale 1ns/1ps
`include "cmsc_defs.svh"

// What this block does
// - Command mode ends by itself once no valid command came for the idle timeout in 100 ms units.
// - An explicit exit command ends command mode at once.
// - The escape is only taken with a full guard time of line silence before and after it.
// - The escape character is a software-set byte, 0x2B after reset.
// - Sleep select 0 means no sleep, 1 pin sleep, 4 cyclic sleep, 0 after reset.
// - Select 0 makes a router that never sleeps, and a change of select forces a rejoin.
// - After waking with no radio data pending the awake pin stays low for the skip count periods.
// - An end device sleeps one period of the sleep duration in 10 ms units, 0x20 to 0xAF0.
// - On a parent the sleep duration also gives how long a child message is held.
// - The idle-before-sleep timer restarts on any serial or radio datum and allows sleep on expiry.
// - Option 0x02 always wakes for the idle time and 0x04 sleeps the full count times period.
module cmsc_top #(
  parameter int MS_CYCLES = `CMSC_MS_CYCLES
) (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        reset,
  // avalon-mm slave
  input  wire logic [5:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  output logic [31:0]      readdata,
  output logic             waitrequest,
  // serial side, same clock
  input  wire logic        rxValid,
  input  wire logic [7:0]  rxByte,
  input  wire logic        cmdValid,
  input  wire logic        cmdExit,
  // radio side, same clock
  input  wire logic        rfRx,
  input  wire logic        rfPending,
  // sleep request pin, asynchronous
  input  wire logic        sleepRqPin,
  // results
  output logic             cmdMode,
  output logic             awakePin,
  output logic             lowPower,
  output logic             endDevice,
  output logic             rejoinReq,
  output logic [15:0]      parentHoldTime
);

  localparam int MSW = $clog2(MS_CYCLES);

  // ****************************************************************
  // time bases
  // ****************************************************************
  logic [MSW-1:0] msCnt_r, msCnt_nxt;
  logic [3:0]     tenCnt_r, tenCnt_nxt, hunCnt_r, hunCnt_nxt;
  logic           msTick_r, msTick_nxt, tenTick_r, tenTick_nxt, hunTick_r, hunTick_nxt;

  // cascaded dividers, each tick one cycle long
  always_comb begin
    msTick_nxt  = (msCnt_r == MSW'(MS_CYCLES - 1));
    msCnt_nxt   = msTick_nxt ? '0 : msCnt_r + 1'b1;
    tenCnt_nxt  = tenCnt_r;
    hunCnt_nxt  = hunCnt_r;
    tenTick_nxt = 1'b0;
    hunTick_nxt = 1'b0;
    if (msTick_r) begin
      tenTick_nxt = (tenCnt_r == `CMSC_MS_PER_10MS - 4'h1);
      tenCnt_nxt  = tenTick_nxt ? 4'h0 : tenCnt_r + 4'h1;
    end
    if (tenTick_r) begin
      hunTick_nxt = (hunCnt_r == `CMSC_10MS_PER_100MS - 4'h1);
      hunCnt_nxt  = hunTick_nxt ? 4'h0 : hunCnt_r + 4'h1;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      msCnt_r   <= '0;
      tenCnt_r  <= 4'h0;
      hunCnt_r  <= 4'h0;
      msTick_r  <= 1'b0;
      tenTick_r <= 1'b0;
      hunTick_r <= 1'b0;
    end else begin
      msCnt_r   <= msCnt_nxt;
      tenCnt_r  <= tenCnt_nxt;
      hunCnt_r  <= hunCnt_nxt;
      msTick_r  <= msTick_nxt;
      tenTick_r <= tenTick_nxt;
      hunTick_r <= hunTick_nxt;
    end
  end

  // ****************************************************************
  // sleep request pin synchroniser
  // ****************************************************************
  logic sync1_r, sync2_r, sync3_r, sleepRq_r;

  // a change counts only once stages two and three agree
  always_ff @(posedge clock) begin
    if (reset) begin
      sync1_r   <= 1'b0;
      sync2_r   <= 1'b0;
      sync3_r   <= 1'b0;
      sleepRq_r <= 1'b0;
    end else begin
      sync1_r <= sleepRqPin;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      if (sync2_r == sync3_r) begin
        sleepRq_r <= sync3_r;
      end
    end
  end

  // ****************************************************************
  // register bus
  // ****************************************************************
  cmsc_pkg::cmsc_cfg_t    cfg_r, cfg_nxt;
  cmsc_pkg::cmsc_status_t status;
  cmsc_pkg::cmsc_esc_t    esc_r, esc_nxt;
  cmsc_pkg::cmsc_sleep_t  sl_r, sl_nxt;
  logic        ack_r, ack_nxt, waitreq_r, waitreq_nxt, rejoin_r, rejoin_nxt;
  logic        wrEn;
  logic [31:0] rdata_r, rdata_nxt, rdMux;
  logic        cmdMode_r, cmdMode_nxt, awake_r, awake_nxt, lowPower_r, lowPower_nxt;

  assign wrEn = write && ack_r; // write lands on the edge that sees waitrequest low

  // read mux, unmapped offsets read zero
  always_comb begin
    case (address)
      `CMSC_ADDR_IDLE:   rdMux = 32'(cfg_r.idleTimeout);
      `CMSC_ADDR_GUARD:  rdMux = 32'(cfg_r.guardTime);
      `CMSC_ADDR_ESC:    rdMux = 32'(cfg_r.escChar);
      `CMSC_ADDR_SEL:    rdMux = 32'(cfg_r.sleepSel);
      `CMSC_ADDR_SKIP:   rdMux = 32'(cfg_r.wakeSkip);
      `CMSC_ADDR_DUR:    rdMux = 32'(cfg_r.sleepDur);
      `CMSC_ADDR_ST:     rdMux = 32'(cfg_r.idleBeforeSleep);
      `CMSC_ADDR_OPT:    rdMux = 32'(cfg_r.sleepOpt);
      `CMSC_ADDR_STATUS: rdMux = 32'(status);
      default:           rdMux = 32'h0000_0000;
    endcase
  end

  // one wait cycle per access; out-of-range values are clamped, bad selects dropped
  always_comb begin
    ack_nxt     = (read || write) && !ack_r;
    waitreq_nxt = !ack_nxt;
    rdata_nxt   = (read && !ack_r) ? rdMux : rdata_r;
    cfg_nxt     = cfg_r;
    rejoin_nxt  = 1'b0;
    if (wrEn) begin
      case (address)
        `CMSC_ADDR_IDLE:  cfg_nxt.idleTimeout = cmsc_pkg::clamp16(writedata[15:0],
                            `CMSC_MIN_IDLE, `CMSC_MAX_IDLE);
        `CMSC_ADDR_GUARD: cfg_nxt.guardTime = cmsc_pkg::clamp16(writedata[15:0],
                            `CMSC_MIN_GUARD, `CMSC_MAX_GUARD);
        `CMSC_ADDR_ESC:   cfg_nxt.escChar = writedata[7:0];
        `CMSC_ADDR_SEL: begin
          if (writedata[2:0] == `CMSC_SEL_OFF || writedata[2:0] == `CMSC_SEL_PIN ||
              writedata[2:0] == `CMSC_SEL_CYC) begin
            cfg_nxt.sleepSel = writedata[2:0];
            rejoin_nxt       = (writedata[2:0] != cfg_r.sleepSel);
          end
        end
        `CMSC_ADDR_SKIP:  cfg_nxt.wakeSkip = cmsc_pkg::clamp16(writedata[15:0],
                            `CMSC_MIN_SKIP, `CMSC_MAX_SKIP);
        `CMSC_ADDR_DUR:   cfg_nxt.sleepDur = cmsc_pkg::clamp16(writedata[15:0],
                            `CMSC_MIN_DUR, `CMSC_MAX_DUR);
        `CMSC_ADDR_ST:    cfg_nxt.idleBeforeSleep = cmsc_pkg::clamp16(writedata[15:0],
                            `CMSC_MIN_ST, `CMSC_MAX_ST);
        `CMSC_ADDR_OPT:   cfg_nxt.sleepOpt = writedata[7:0];
        default:          cfg_nxt = cfg_r;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      ack_r     <= 1'b0;
      waitreq_r <= 1'b1;
      rdata_r   <= 32'h0000_0000;
      rejoin_r  <= 1'b0;
      cfg_r     <= '{`CMSC_RST_IDLE, `CMSC_RST_GUARD, `CMSC_RST_ESC, `CMSC_SEL_OFF,
                     `CMSC_RST_SKIP, `CMSC_RST_DUR, `CMSC_RST_ST, `CMSC_RST_OPT};
    end else begin
      ack_r     <= ack_nxt;
      waitreq_r <= waitreq_nxt;
      rdata_r   <= rdata_nxt;
      rejoin_r  <= rejoin_nxt;
      cfg_r     <= cfg_nxt;
    end
  end

  // ****************************************************************
  // timers
  // ****************************************************************
  logic guardDone, cmdIdleDone, idleDone, slpDone;

  // silence since the last serial byte
  cmsc_timer #(.W(16)) u_guard (.clock(clock), .reset(reset), .restart(rxValid),
    .tick(msTick_r), .limit(cfg_r.guardTime), .done(guardDone));
  // held clear outside command mode, restarted by each valid command
  cmsc_timer #(.W(16)) u_cmdIdle (.clock(clock), .reset(reset),
    .restart(cmdValid || !cmdMode_r), .tick(hunTick_r),
    .limit(cfg_r.idleTimeout), .done(cmdIdleDone));
  // any serial or radio datum pushes sleep out again
  cmsc_timer #(.W(16)) u_idle (.clock(clock), .reset(reset),
    .restart(rxValid || rfRx || sl_r != cmsc_pkg::SL_AWAKE), .tick(msTick_r),
    .limit(cfg_r.idleBeforeSleep), .done(idleDone));
  // one sleep period, rearmed at each period end
  cmsc_timer #(.W(16)) u_sleep (.clock(clock), .reset(reset),
    .restart(sl_r != cmsc_pkg::SL_ASLEEP || slpDone), .tick(tenTick_r),
    .limit(cfg_r.sleepDur), .done(slpDone));

  // ****************************************************************
  // escape recognition and command mode
  // ****************************************************************
  logic escHit;

  assign escHit = rxValid && (rxByte == cfg_r.escChar);

  // guard, three escape bytes, guard; a long gap mid-sequence also cancels
  always_comb begin
    esc_nxt     = esc_r;
    cmdMode_nxt = cmdMode_r;
    case (esc_r)
      cmsc_pkg::ESC_WAIT: if (escHit && guardDone && !cmdMode_r) esc_nxt = cmsc_pkg::ESC_GOT1;
      cmsc_pkg::ESC_GOT1: begin
        if (rxValid) esc_nxt = escHit ? cmsc_pkg::ESC_GOT2 : cmsc_pkg::ESC_WAIT;
        else if (guardDone) esc_nxt = cmsc_pkg::ESC_WAIT;
      end
      cmsc_pkg::ESC_GOT2: begin
        if (rxValid) esc_nxt = escHit ? cmsc_pkg::ESC_GOT3 : cmsc_pkg::ESC_WAIT;
        else if (guardDone) esc_nxt = cmsc_pkg::ESC_WAIT;
      end
      cmsc_pkg::ESC_GOT3: begin
        if (rxValid) begin
          esc_nxt = cmsc_pkg::ESC_WAIT; // a fourth byte too soon
        end else if (guardDone) begin
          esc_nxt     = cmsc_pkg::ESC_WAIT;
          cmdMode_nxt = 1'b1; // trailing silence complete
        end
      end
      default: esc_nxt = cmsc_pkg::ESC_WAIT;
    endcase
    if (cmdMode_r && (cmdExit || cmdIdleDone)) begin
      cmdMode_nxt = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      esc_r     <= cmsc_pkg::ESC_WAIT;
      cmdMode_r <= 1'b0;
    end else begin
      esc_r     <= esc_nxt;
      cmdMode_r <= cmdMode_nxt;
    end
  end

  // ****************************************************************
  // sleep control
  // ****************************************************************
  logic [15:0] periods_r, periods_nxt;
  logic        skipDone, showPin;

  // pin shown after the skip count, or early for pending radio data unless full span asked
  assign skipDone = ({1'b0, periods_r} + 17'h0_0001) >= {1'b0, cfg_r.wakeSkip};
  assign showPin  = skipDone || (rfPending && !cfg_r.sleepOpt[`CMSC_OPT_FULL]);

  always_comb begin
    sl_nxt      = sl_r;
    awake_nxt   = awake_r;
    periods_nxt = periods_r;
    case (sl_r)
      cmsc_pkg::SL_AWAKE: begin
        if (cfg_r.sleepSel == `CMSC_SEL_OFF) begin
          awake_nxt = 1'b1; // a router stays up
        end else if (cfg_r.sleepSel == `CMSC_SEL_PIN && sleepRq_r) begin
          sl_nxt    = cmsc_pkg::SL_ASLEEP;
          awake_nxt = 1'b0;
        end else if (cfg_r.sleepSel == `CMSC_SEL_CYC && idleDone && !cmdMode_r &&
                     !rxValid && !rfRx) begin // a datum in the expiry cycle still wins
          sl_nxt    = cmsc_pkg::SL_ASLEEP;
          awake_nxt = 1'b0;
          if (awake_r) periods_nxt = 16'h0000; // quiet wakes keep counting
        end
      end
      cmsc_pkg::SL_ASLEEP: begin
        if (cfg_r.sleepSel == `CMSC_SEL_OFF ||
            (cfg_r.sleepSel == `CMSC_SEL_PIN && !sleepRq_r)) begin
          sl_nxt    = cmsc_pkg::SL_AWAKE;
          awake_nxt = 1'b1;
        end else if (cfg_r.sleepSel == `CMSC_SEL_CYC && slpDone) begin
          periods_nxt = periods_r + 16'h0001;
          if (showPin) begin
            sl_nxt    = cmsc_pkg::SL_AWAKE;
            awake_nxt = 1'b1;
          end else if (cfg_r.sleepOpt[`CMSC_OPT_WAKE_ST]) begin
            sl_nxt = cmsc_pkg::SL_AWAKE; // up for the idle time, pin low
          end
        end
      end
      default: sl_nxt = cmsc_pkg::SL_AWAKE;
    endcase
    lowPower_nxt = (sl_nxt == cmsc_pkg::SL_ASLEEP);
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      sl_r       <= cmsc_pkg::SL_AWAKE;
      awake_r    <= 1'b1;
      lowPower_r <= 1'b0;
      periods_r  <= 16'h0000;
    end else begin
      sl_r       <= sl_nxt;
      awake_r    <= awake_nxt;
      lowPower_r <= lowPower_nxt;
      periods_r  <= periods_nxt;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  logic        endDev_r;
  logic [15:0] hold_r;

  // hold time for children follows the sleep duration
  always_ff @(posedge clock) begin
    if (reset) begin
      endDev_r <= 1'b0;
      hold_r   <= `CMSC_RST_DUR;
    end else begin
      endDev_r <= (cfg_nxt.sleepSel != `CMSC_SEL_OFF);
      hold_r   <= cfg_nxt.sleepDur;
    end
  end

  assign status         = '{esc_r, endDev_r, lowPower_r, awake_r, cmdMode_r};
  assign readdata       = rdata_r;
  assign waitrequest    = waitreq_r;
  assign cmdMode        = cmdMode_r;
  assign awakePin       = awake_r;
  assign lowPower       = lowPower_r;
  assign endDevice      = endDev_r;
  assign rejoinReq      = rejoin_r;
  assign parentHoldTime = hold_r;

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  property p_idle_exit;
    cmdMode_r && cmdIdleDone |=> !cmdMode_r;
  endproperty
  a_idle_exit: assert property (p_idle_exit) else $error("idle timeout left command mode on");

  property p_exit_now;
    cmdMode_r && cmdExit |=> !cmdMode_r ##1 !cmdMode_r;
  endproperty
  a_exit_now: assert property (p_exit_now) else $error("exit command ignored");

  property p_guard_before;
    esc_r == cmsc_pkg::ESC_WAIT && rxValid && !guardDone |=> esc_r == cmsc_pkg::ESC_WAIT;
  endproperty
  a_guard_before: assert property (p_guard_before) else $error("escape without guard");

  property p_enter;
    esc_r == cmsc_pkg::ESC_GOT3 && !rxValid && guardDone && !cmdMode_r |=> cmdMode_r;
  endproperty
  a_enter: assert property (p_enter) else $error("complete escape not taken");

  property p_wrong_char;
    esc_r != cmsc_pkg::ESC_WAIT && rxValid && rxByte != cfg_r.escChar
      |=> esc_r == cmsc_pkg::ESC_WAIT;
  endproperty
  a_wrong_char: assert property (p_wrong_char) else $error("foreign byte kept escape");

  property p_router;
    cfg_r.sleepSel == `CMSC_SEL_OFF |=> !lowPower_r && awake_r;
  endproperty
  a_router: assert property (p_router) else $error("router went to sleep");

  property p_rejoin;
    cfg_r.sleepSel != $past(cfg_r.sleepSel) |-> rejoinReq;
  endproperty
  a_rejoin: assert property (p_rejoin) else $error("select change without rejoin");

  property p_skip;
    sl_r == cmsc_pkg::SL_ASLEEP && cfg_r.sleepSel == `CMSC_SEL_CYC && slpDone && !showPin
      |=> !awake_r;
  endproperty
  a_skip: assert property (p_skip) else $error("awake pin raised inside skip count");

  property p_period;
    sl_r == cmsc_pkg::SL_ASLEEP && cfg_r.sleepSel == `CMSC_SEL_CYC && !slpDone |=> lowPower_r;
  endproperty
  a_period: assert property (p_period) else $error("woke before period end");

  property p_st_restart;
    sl_r == cmsc_pkg::SL_AWAKE && cfg_r.sleepSel == `CMSC_SEL_CYC && (rxValid || rfRx)
      |=> !lowPower_r ##1 !lowPower_r;
  endproperty
  a_st_restart: assert property (p_st_restart) else $error("slept right after data");

  property p_full_span;
    sl_r == cmsc_pkg::SL_ASLEEP && cfg_r.sleepSel == `CMSC_SEL_CYC && slpDone && !skipDone &&
      cfg_r.sleepOpt[`CMSC_OPT_FULL] |=> !awake_r;
  endproperty
  a_full_span: assert property (p_full_span) else $error("full span option broken");

endmodule // cmsc_top

/* File: cmsc_defs.svh */
`ifndef CMSC_DEFS_SVH
`define CMSC_DEFS_SVH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define CMSC_ADDR_IDLE    6'h00
`define CMSC_ADDR_GUARD   6'h04
`define CMSC_ADDR_ESC     6'h08
`define CMSC_ADDR_SEL     6'h0C
`define CMSC_ADDR_SKIP    6'h10
`define CMSC_ADDR_DUR     6'h14
`define CMSC_ADDR_ST      6'h18
`define CMSC_ADDR_OPT     6'h1C
`define CMSC_ADDR_STATUS  6'h20

// ****************************************************************
// reset values and legal ranges
// ****************************************************************
`define CMSC_RST_IDLE     16'h0064
`define CMSC_MIN_IDLE     16'h0002
`define CMSC_MAX_IDLE     16'h028F
`define CMSC_RST_GUARD    16'h03E8
`define CMSC_MIN_GUARD    16'h0001
`define CMSC_MAX_GUARD    16'h0CE4
`define CMSC_RST_ESC      8'h2B
`define CMSC_RST_SKIP     16'h0001
`define CMSC_MIN_SKIP     16'h0001
`define CMSC_MAX_SKIP     16'hFFFF
`define CMSC_RST_DUR      16'h0020
`define CMSC_MIN_DUR      16'h0020
`define CMSC_MAX_DUR      16'h0AF0
`define CMSC_RST_ST       16'h1388
`define CMSC_MIN_ST       16'h0001
`define CMSC_MAX_ST       16'hFFFE
`define CMSC_RST_OPT      8'h00

// ****************************************************************
// sleep select codes and option bits
// ****************************************************************
`define CMSC_SEL_OFF      3'h0
`define CMSC_SEL_PIN      3'h1
`define CMSC_SEL_CYC      3'h4
`define CMSC_OPT_WAKE_ST  1
`define CMSC_OPT_FULL     2

// ****************************************************************
// time bases
// ****************************************************************
`define CMSC_CLK_PERIOD_PS  25000
`define CMSC_MS_PS          1000000000
`define CMSC_MS_CYCLES      (`CMSC_MS_PS / `CMSC_CLK_PERIOD_PS)
`define CMSC_MS_PER_10MS    4'hA
`define CMSC_10MS_PER_100MS 4'hA

`endif

/* File: cmsc_pkg.sv */
package cmsc_pkg;

  // ****************************************************************
  // states
  // ****************************************************************
  typedef enum logic [2:0] {ESC_WAIT, ESC_GOT1, ESC_GOT2, ESC_GOT3} cmsc_esc_t;
  typedef enum logic [1:0] {SL_AWAKE, SL_ASLEEP} cmsc_sleep_t;

  // ****************************************************************
  // software settings
  // ****************************************************************
  typedef struct packed {
    logic [15:0] idleTimeout;
    logic [15:0] guardTime;
    logic [7:0]  escChar;
    logic [2:0]  sleepSel;
    logic [15:0] wakeSkip;
    logic [15:0] sleepDur;
    logic [15:0] idleBeforeSleep;
    logic [7:0]  sleepOpt;
  } cmsc_cfg_t;

  // status word, low bits
  typedef struct packed {
    logic [2:0] escStage;
    logic       endDevice;
    logic       lowPower;
    logic       awakePin;
    logic       cmdMode;
  } cmsc_status_t;

  // force a written value into its legal window
  function automatic logic [15:0] clamp16(input logic [15:0] v,
                                          input logic [15:0] lo,
                                          input logic [15:0] hi);
    clamp16 = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

endpackage

/* File: cmsc_timer.sv */
`timescale 1ns/1ps

// elapsed-time counter: counts ticks since restart, saturates at limit
module cmsc_timer #(
  parameter int W = 16
) (
  // clock and reset
  input  wire logic         clock,
  input  wire logic         reset,
  // control
  input  wire logic         restart,
  input  wire logic         tick,
  input  wire logic [W-1:0] limit,
  // result
  output logic              done
);

  logic [W-1:0] count_r;
  logic [W-1:0] count_nxt;
  logic         done_r;
  logic         done_nxt;

  // saturating count, restart wins over a tick
  always_comb begin
    count_nxt = count_r;
    if (restart) begin
      count_nxt = '0;
    end else if (tick && (count_r < limit)) begin
      count_nxt = count_r + 1'b1;
    end
    done_nxt = !restart && (count_nxt >= limit);
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      count_r <= '0;
      done_r  <= 1'b0;
    end else begin
      count_r <= count_nxt;
      done_r  <= done_nxt;
    end
  end

  assign done = done_r;

endmodule // cmsc_timer

/* File: cmsc_host_model.sv */
`timescale 1ns/1ps

// ****************************************************************
// serial host on the far side of the block
// ****************************************************************
module cmsc_host_model (
  // clock
  input  wire logic        clock,
  // serial strobes toward the block
  output logic             rxValid,
  output logic [7:0]       rxByte,
  output logic             cmdValid,
  output logic             cmdExit
);
  // idle line starts quiet
  initial begin
    rxValid  = 1'b0;
    rxByte   = 8'h00;
    cmdValid = 1'b0;
    cmdExit  = 1'b0;
  end

  // one byte strobe; data flips once released so stale data never looks valid
  task automatic sendByte(input logic [7:0] b);
    rxValid <= 1'b1;
    rxByte  <= b;
    @(posedge clock);
    rxValid <= 1'b0;
    rxByte  <= ~b;
  endtask

  // parsed command strobe, restarts the command idle timer
  task automatic sendCmd();
    cmdValid <= 1'b1;
    @(posedge clock);
    cmdValid <= 1'b0;
  endtask

  // explicit exit, a single-cycle pulse
  task automatic sendExit();
    cmdExit <= 1'b1;
    @(posedge clock);
    cmdExit <= 1'b0;
  endtask
endmodule // cmsc_host_model

/* File: command_mode_sleep_control_tb.sv */
`timescale 1ns/1ps
`include "cmsc_defs.svh"

module command_mode_sleep_control_tb;
  // ****************************************************************
  // clock, reset and ports
  // ****************************************************************
  logic        clock = 1'b0;
  logic        reset = 1'b1;
  logic [5:0]  address = 6'h00;
  logic        read = 1'b0;
  logic        write = 1'b0;
  logic [31:0] writedata = 32'h0000_0000;
  logic        sleepRqPin = 1'b0;
  logic [31:0] readdata, q;
  logic        waitrequest, rxValid, cmdValid, cmdExit, cmdMode, awakePin;
  logic        lowPower, endDevice, rejoinReq;
  logic [7:0]  rxByte;
  logic [15:0] parentHoldTime;
  int          miscompares = 0;
  int          n_checks = 0;
  int          nRejoin = 0;
  int          cyc = 0;

  initial begin
    forever #12.5 clock = ~clock;
  end

  // 4 cycles per ms keeps the long timers short
  cmsc_top #(.MS_CYCLES(4)) dut_u (.clock(clock), .reset(reset), .address(address),
    .read(read), .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .rxValid(rxValid), .rxByte(rxByte), .cmdValid(cmdValid),
    .cmdExit(cmdExit), .rfRx(1'b0), .rfPending(1'b0), .sleepRqPin(sleepRqPin),
    .cmdMode(cmdMode), .awakePin(awakePin), .lowPower(lowPower), .endDevice(endDevice),
    .rejoinReq(rejoinReq), .parentHoldTime(parentHoldTime));

  cmsc_host_model host_u (.clock(clock), .rxValid(rxValid), .rxByte(rxByte),
    .cmdValid(cmdValid), .cmdExit(cmdExit));

  // ****************************************************************
  // helpers
  // ****************************************************************
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // hang guard, well above the cyclic sleep period
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      miscompares = miscompares + 1;
      final_report();
    end
  end

  // rejoin pulses last one cycle, so they are counted as they pass
  always @(posedge clock) begin
    if (rejoinReq === 1'b1) nRejoin <= nRejoin + 1;
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // request held until waitrequest is seen low at a rising edge; one idle edge after release
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    read      <= ~wr;
    write     <= wr;
    address   <= a;
    writedata <= d;
    do begin
      @(posedge clock);
    end while (waitrequest !== 1'b0);
    q = readdata;
    read  <= 1'b0;
    write <= 1'b0;
    @(posedge clock);
  endtask

  function automatic logic sig(input int s);
    sig = (s == 0) ? cmdMode : (s == 1) ? lowPower : (s == 2) ? endDevice : awakePin;
  endfunction

  // bounded wait for a level, then compare
  task automatic waitLvl(input int s, input logic v, input int n);
    int k;
    k = 0;
    @(negedge clock);
    while (sig(s) !== v && k < n) begin
      @(negedge clock);
      k++;
    end
    chk(sig(s), v);
    @(posedge clock);
  endtask

  // guard silence, three characters spaced two cycles, middle one chosen
  task automatic escape(input logic [7:0] c, input logic [7:0] mid);
    repeat (20) @(posedge clock);
    host_u.sendByte(c);
    @(posedge clock);
    host_u.sendByte(mid);
    @(posedge clock);
    host_u.sendByte(c);
    @(negedge clock);
    chk(cmdMode, 1'b0);
    @(posedge clock);
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_resetValues();
    logic [5:0]  a[9] = '{6'h00, 6'h04, 6'h08, 6'h0C, 6'h10, 6'h14, 6'h18, 6'h1C, 6'h24};
    logic [31:0] e[9] = '{32'h64, 32'h3E8, 32'h2B, 32'h0, 32'h1, 32'h20, 32'h1388, 32'h0, 32'h0};
    for (int i = 0; i < 9; i++) begin
      bus(1'b0, a[i], 32'h0000_0000);
      chk(q, e[i]);
    end
    chk(parentHoldTime, 32'h20);
  endtask

  task automatic t_escapeExit();
    bus(1'b1, 6'h04, 32'h0000_0002);
    escape(8'h2B, 8'h2B);
    waitLvl(0, 1'b1, 40);
    host_u.sendExit();
    waitLvl(0, 1'b0, 2);
    escape(8'h2B, 8'h41);
    repeat (40) @(posedge clock);
    waitLvl(0, 1'b0, 1);
    chk(cmdMode, 1'b0);
  endtask

  task automatic t_newCharTimeout();
    bus(1'b1, 6'h00, 32'h0000_0001);
    bus(1'b0, 6'h00, 32'h0000_0000);
    chk(q, 32'h2);
    bus(1'b1, 6'h08, 32'h0000_0041);
    escape(8'h41, 8'h41);
    waitLvl(0, 1'b1, 40);
    repeat (300) @(posedge clock);
    host_u.sendCmd();
    repeat (300) @(posedge clock);
    host_u.sendCmd();
    repeat (300) @(posedge clock);
    chk(cmdMode, 1'b1);
    waitLvl(0, 1'b0, 1500);
  endtask

  task automatic t_sleep();
    int t0;
    bus(1'b1, 6'h0C, 32'h0000_0001);
    waitLvl(2, 1'b1, 3);
    chk(nRejoin, 32'h1);
    sleepRqPin <= 1'b1;
    waitLvl(1, 1'b1, 10);
    chk(awakePin, 1'b0);
    sleepRqPin <= 1'b0;
    waitLvl(1, 1'b0, 10);
    bus(1'b1, 6'h0C, 32'h0000_0002);
    bus(1'b0, 6'h0C, 32'h0000_0000);
    chk(q, 32'h1);
    chk(nRejoin, 32'h1);
    bus(1'b1, 6'h14, 32'h0000_0010);
    waitLvl(3, 1'b1, 3);
    chk(parentHoldTime, 32'h20);
    bus(1'b1, 6'h18, 32'h0000_0001);
    bus(1'b1, 6'h10, 32'h0000_0002);
    bus(1'b1, 6'h0C, 32'h0000_0004);
    waitLvl(1, 1'b1, 60);
    t0 = cyc;
    chk(nRejoin, 32'h2);
    waitLvl(1, 1'b0, 14000);
    chk(cyc - t0 > 2400 && cyc - t0 < 2700, 1'b1);
    chk(awakePin, 1'b1);
    bus(1'b1, 6'h0C, 32'h0000_0000);
    waitLvl(2, 1'b0, 3);
    chk(nRejoin, 32'h3);
  endtask

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    repeat (16) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    t_resetValues();
    t_escapeExit();
    t_newCharTimeout();
    t_sleep();
    final_report();
  end
endmodule // command_mode_sleep_control_tb
